// File: rtl/hwt_consts.svh
// hibernation wake timer constants: offsets, fields, resets, timing
// assumes inclusion by the wake timer design and checker files only
`ifndef HWT_CONSTS_SVH
`define HWT_CONSTS_SVH

`define HWT_ADR_W 4
`define HWT_OFF_PRELOAD 4'h0
`define HWT_OFF_CONTROL 4'h4
`define HWT_OFF_COUNT 4'h8
`define HWT_CNT_W 16
`define HWT_RST_PRELOAD 16'h0000
`define HWT_RST_CONTROL 16'h0000
`define HWT_RST_COUNT 16'h0000
`define HWT_CTRL_RES_BIT 0
`define HWT_SLOW_HZ 32768
`define HWT_FINE_STEP_US 30.5
`define HWT_COARSE_STEP_MS 125
`define HWT_COARSE_TICKS ((`HWT_COARSE_STEP_MS * `HWT_SLOW_HZ) / 1000)

`endif

// File: rtl/hwt_pkg.sv
// hibernation wake timer types
// assumes hwt_consts.svh for widths
`include "hwt_consts.svh"
package hwt_pkg;
  typedef struct packed {
    logic [`HWT_ADR_W-1:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } hwt_bus_req_t;

  typedef enum logic {
    HWT_RES_FINE,
    HWT_RES_COARSE
  } hwt_res_t;

  typedef enum logic {
    HWT_ST_STOPPED,
    HWT_ST_COUNTING
  } hwt_state_t;
endpackage

// File: rtl/hwt_slow_sync.sv
// two-flop synchroniser for the 32 kHz clock with rising-edge pulse
// assumes slow_clk_i is asynchronous to clk_i
module hwt_slow_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic slow_clk_i,
  output logic tick_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (ce_i) begin
      meta_q <= slow_clk_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign tick_o = ce_i & sync_q & ~prev_q;
endmodule // hwt_slow_sync

// File: rtl/hwt_prescaler.sv
// divides slow clock ticks into count steps for the selected resolution
// assumes tick_i is a one-cycle pulse per 32 kHz period
`include "hwt_consts.svh"

module hwt_prescaler #(
  parameter int COARSE_DIV = `HWT_COARSE_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic restart_i,
  input wire logic tick_i,
  input wire hwt_pkg::hwt_res_t res_i,
  output logic step_o
);
  localparam int DW = (COARSE_DIV > 1) ? $clog2(COARSE_DIV) : 1;
  localparam logic [DW-1:0] LAST = DW'(COARSE_DIV - 1);

  logic [DW-1:0] div_q;

  initial begin
    if (COARSE_DIV < 1) begin
      $error("COARSE_DIV must be at least 1");
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else if (ce_i) begin
      if (restart_i) begin
        div_q <= '0;
      end else if (tick_i) begin
        if (div_q == LAST) begin
          div_q <= '0;
        end else begin
          div_q <= div_q + 1'b1;
        end
      end
    end
  end

  assign step_o = tick_i & ~restart_i &
    ((res_i == hwt_pkg::HWT_RES_FINE) | (div_q == LAST));
endmodule // hwt_prescaler

// File: rtl/hwt_wake_timer.sv
// hibernation wake timer top: wishbone slave, 16-bit down counter
// assumes a 100 MHz clk_i and a free 32 kHz slow clock input
//
// Operation
// - when enabled and the count steps down to zero, a wake pulse is raised.
// - counting is paced by the 32 kHz clock, independent of the main clock.
// - sleep enable inputs never stop or alter counting.
// - clock request is raised for one cycle only, together with the bus acknowledge.
// - a non-zero preload write reloads the counter and starts it.
// - a zero preload write stops the counter with no wake.
// - resolution bit one gives 0.125 s per count step.
// - resolution bit zero gives 30.5 us per count step.
// - the count register reads the live counter value.
// - preload at 00h, control at 04h, count at 08h.
// - the counter is a 16-bit binary down counter.
// - system reset clears preload, control, count and all logic.
`include "hwt_consts.svh"

module hwt_wake_timer #(
  parameter int COARSE_DIV = `HWT_COARSE_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic slow_clk_i,
  input wire logic [1:0] sleep_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`HWT_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic clk_req_o,
  output logic wake_timer_irq_o
);
  localparam int CW = `HWT_CNT_W;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_PRELOAD = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_COUNT = 2'h3;

  // bus request as one packed word
  hwt_pkg::hwt_bus_req_t req;

  // timer state
  hwt_pkg::hwt_state_t state_q;
  hwt_pkg::hwt_res_t res_q;
  logic [CW-1:0] start_value_q;
  logic [CW-1:0] count_q;
  logic irq_q;

  // bus answer state
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic req_q;

  // decode and pacing
  logic access;
  logic wr_preload;
  logic wr_control;
  logic rd_strobe;
  logic [CW-1:0] preload_d;
  logic tick;
  logic step;
  logic last_step;

  // refuse settings the logic cannot serve
  if (COARSE_DIV < 1) begin : g_bad_div
    $error("COARSE_DIV must be at least 1");
  end
  if (CW != 16) begin : g_bad_cw
    $error("count width must be 16 bits");
  end
  if (`HWT_ADR_W < 4) begin : g_bad_adr
    $error("address must reach offset 08h");
  end

  // register select from a byte offset
  function automatic logic [1:0] reg_select(
    input logic [`HWT_ADR_W-1:0] adr
  );
    logic [1:0] s;
    s = SEL_NONE;
    if (adr == `HWT_OFF_PRELOAD) begin
      s = SEL_PRELOAD;
    end else if (adr == `HWT_OFF_CONTROL) begin
      s = SEL_CONTROL;
    end else if (adr == `HWT_OFF_COUNT) begin
      s = SEL_COUNT;
    end
    return s;
  endfunction

  // byte lane merge, lanes 2 and 3 ignored
  function automatic logic [CW-1:0] merge16(input logic [CW-1:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [CW-1:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
  assign access = wb_cyc_i & wb_stb_i & ~ack_q;
  assign preload_d = merge16(start_value_q, req.dat, req.sel);

  // register decode for writes and reads
  always_comb begin
    wr_preload = 1'b0;
    wr_control = 1'b0;
    rd_strobe = 1'b0;
    if (access) begin
      if (req.we) begin
        if (reg_select(req.adr) == SEL_PRELOAD) begin
          wr_preload = 1'b1;
        end else if (reg_select(req.adr) == SEL_CONTROL) begin
          wr_control = 1'b1;
        end
      end else begin
        rd_strobe = 1'b1;
      end
    end
  end

  // read data mux, unmapped reads zero
  always_comb begin
    rdat_d = 32'h00000000;
    if (reg_select(req.adr) == SEL_PRELOAD) begin
      rdat_d = {16'h0000, start_value_q};
    end else if (reg_select(req.adr) == SEL_CONTROL) begin
      rdat_d = {31'h00000000, res_q == hwt_pkg::HWT_RES_COARSE};
    end else if (reg_select(req.adr) == SEL_COUNT) begin
      rdat_d = {16'h0000, count_q};
    end
  end

  // the step that takes the count from one to zero
  assign last_step = ~wr_preload & step & (count_q == 16'h0001) &
                     (state_q == hwt_pkg::HWT_ST_COUNTING);

  hwt_slow_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .slow_clk_i(slow_clk_i),
    .tick_o(tick)
  );

  hwt_prescaler #(
    .COARSE_DIV(COARSE_DIV)
  ) u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .restart_i(wr_preload),
    .tick_i(tick),
    .res_i(res_q),
    .step_o(step)
  );

  // bus acknowledge, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= access;
    end
  end

  // read data register, holds until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h00000000;
    end else if (ce_i & rd_strobe) begin
      rdat_q <= rdat_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_value_q <= `HWT_RST_PRELOAD;
    end else if (ce_i & wr_preload) begin
      start_value_q <= preload_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_q <= hwt_pkg::HWT_RES_FINE;
    end else if (ce_i & wr_control & req.sel[0]) begin
      res_q <= req.dat[`HWT_CTRL_RES_BIT] ? hwt_pkg::HWT_RES_COARSE
                                           : hwt_pkg::HWT_RES_FINE;
    end
  end

  // sleep_en_i deliberately not used in counting
  // 16-bit down counter, holds at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= hwt_pkg::HWT_ST_STOPPED;
      count_q <= `HWT_RST_COUNT;
    end else if (ce_i) begin
      if (wr_preload) begin
        count_q <= preload_d;
        state_q <= (preload_d != '0) ? hwt_pkg::HWT_ST_COUNTING
                                     : hwt_pkg::HWT_ST_STOPPED;
      end else begin
        case (state_q)
          hwt_pkg::HWT_ST_STOPPED: begin
            state_q <= hwt_pkg::HWT_ST_STOPPED;
          end
          hwt_pkg::HWT_ST_COUNTING: begin
            if (step) begin
              count_q <= count_q - 1'b1;
            end
            if (last_step) begin
              state_q <= hwt_pkg::HWT_ST_STOPPED;
            end
          end
          default: begin
            state_q <= hwt_pkg::HWT_ST_STOPPED;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= last_step;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
    end else if (ce_i) begin
      req_q <= access;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign clk_req_o = req_q;
  assign wake_timer_irq_o = irq_q;
endmodule // hwt_wake_timer

// File: sim/hwt_wake_timer_chk.sv
// checker for the wake timer bus answer and pulse outputs
// assumes binding to hwt_wake_timer, one clock domain
`include "hwt_consts.svh"
module hwt_wake_timer_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`HWT_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic clk_req_o,
  input wire logic wake_timer_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence zero_wr;
    taken ##0 (wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[1:0] == 2'h3
      && wb_dat_i[15:0] == 16'h0000);
  endsequence
  sequence gap_rd;
    taken ##0 (!wb_we_i && !(wb_adr_i inside {4'h0, 4'h4, 4'h8}));
  endsequence
  a_ack_next: assert property (taken |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_req_with_ack: assert property (clk_req_o == wb_ack_o)
    else $error("clock request outside access");
  a_irq_pulse: assert property (wake_timer_irq_o && ce_i |=> !wake_timer_irq_o)
    else $error("wake pulse too long");
  a_zero_quiet: assert property (zero_wr |=> !wake_timer_irq_o [*8])
    else $error("wake after stop");
  a_gap_reads_zero: assert property (gap_rd |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits set");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !clk_req_o && !wake_timer_irq_o && wb_dat_o == 32'h0)
    else $error("outputs not cleared by reset");
endmodule // hwt_wake_timer_chk

bind hwt_wake_timer hwt_wake_timer_chk i_hwt_wake_timer_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .clk_req_o(clk_req_o),
  .wake_timer_irq_o(wake_timer_irq_o));

// File: sim/hwt_wake_timer_test.sv
// self-checking bench for the wake timer over wishbone
// assumes a free 32 kHz slow clock and a shortened coarse divider
module hwt_wake_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 3052;
  logic clk_i = 1'b0, rst_i = 1'b1, slow_clk_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, creq;
  logic [1:0] sleep_en_i = 2'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0, q, dat_o;
  int errors = 0, checks_done = 0, n;
  always #5 clk_i = ~clk_i;
  always #15259 slow_clk_i = ~slow_clk_i;
  hwt_wake_timer #(.COARSE_DIV(4)) i_hwt_wake_timer (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(1'b1), .slow_clk_i(slow_clk_i),
    .sleep_en_i(sleep_en_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .clk_req_o(creq),
    .wake_timer_irq_o(irq));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    chk("clk_req", 32'h1, {31'h0, creq});
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string s);
    bus(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask
  task automatic ld(input logic [15:0] v);
    @(negedge slow_clk_i);
    @(posedge clk_i);
    bus(1'b1, 4'h0, {16'h0, v});
  endtask
  task automatic wirq(input int lim);
    n = 0;
    while (n < lim && irq !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  initial begin
    #800000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(4'h0, 32'h0, "preload");
    rd(4'h8, 32'h0, "count");
    rd(4'hC, 32'h0, "unmapped");
    bus(1'b1, 4'h4, 32'h1);
    rd(4'h4, 32'h1, "control");
    bus(1'b1, 4'h4, 32'h0);
    sleep_en_i <= 2'h3;
    ld(16'h0003);
    wirq(4 * P);
    chk("fine", 32'h1, 32'(n >= 2 * P && n <= 3 * P));
    rd(4'h8, 32'h0, "expired");
    wirq(2 * P);
    chk("reload", 32'(2 * P), 32'(n));
    ld(16'hFFFF);
    rd(4'h8, 32'hFFFF, "loaded");
    repeat (P) @(posedge clk_i);
    rd(4'h8, 32'hFFFE, "live");
    bus(1'b1, 4'h0, 32'h0);
    rd(4'h8, 32'h0, "stopped");
    wirq(2 * P);
    chk("no wake", 32'(2 * P), 32'(n));
    bus(1'b1, 4'h4, 32'h1);
    ld(16'h0002);
    wirq(9 * P);
    chk("coarse", 32'h1, 32'(n >= 4 * P && n <= 8 * P));
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(4'h4, 32'h0, "ctl reset");
    tally_and_finish();
  end
endmodule // hwt_wake_timer_test
